// file: rtl/reclose_sequencer_sync_supervision.v
// Operation
// - settable reclose count, four at most
// - reopen after last shot goes lockout
// - lockout left only by manual close
// - held closed, wait reset time, ready
// - first shot immediate unless delay set
// - sync needs magnitude and angle inside
// - each shot selects its own supervisions
// - external inputs true only at rated voltage
// - source setting picks external inputs instead
// - intermediate lockout only on last shot
// - intermediate lockout waits, no timeout
// - alarm asserted during intermediate lockout
// - hold freezes all reclose timers
// - skip bypasses pending shot, advance
// - drive-to-lockout forces lockout anywhere
// - two outputs from AND/OR of inputs
// - separate alarm outputs per condition
//
// The placing of the registers and the APB register port are this design's own decisions.
`include "reclose_map.vh"
`timescale 1ns/100ps
`default_nettype none

module reclose_sequencer_sync_supervision #(
  parameter TICK_CYCLES = `TICK_MS_NS / `CLK_NS
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // breaker and relay contacts
  input  wire        breaker_open,
  input  wire        reclose_initiate,
  input  wire        manual_close,
  input  wire        hold_in,
  input  wire        skip_in,
  input  wire        drive_lockout,
  // external supervision, high at rated voltage
  input  wire        ext_sync_ok,
  input  wire        ext_hot_bus_dead_line_check_ok,
  input  wire        ext_hot_line_dead_bus_check_ok,
  // internal measurement flags
  input  wire        line_hot,
  input  wire        line_dead,
  input  wire        bus_hot,
  input  wire        bus_dead,
  // programmable logic
  input  wire [7:0]  prog_in,
  output reg  [1:0]  prog_out,
  // commands and alarms
  output reg         close_cmd,
  output reg         alarm_check_fail,
  output reg         alarm_intermediate_lockout,
  output reg         alarm_reclose_fail,
  output reg         alarm_lockout,
  output reg         alarm_in_progress
);

  localparam S_READY = 3'h0;
  localparam S_DEAD  = 3'h1;
  localparam S_CLOSE = 3'h2;
  localparam S_RESET = 3'h3;
  localparam S_ILO   = 3'h4;
  localparam S_LOCK  = 3'h5;

  reg  [31:0] ctrl_q;
  reg  [31:0] shot_q [0:3];
  reg  [31:0] reset_t_q;
  reg  [31:0] lim_q;
  reg  [31:0] logic_q;
  reg  [15:0] volt_diff_q;
  reg  [15:0] angle_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [2:0]  count_q;
  reg  [2:0]  count_d;
  reg  [15:0] timer_q;
  reg  [15:0] timer_d;
  reg  [31:0] tick_cnt_q;
  reg         tick_q;
  reg         close_d;
  reg         fail_d;

  wire [2:0]  shots_set;
  wire [2:0]  shots;
  wire [1:0]  idx;
  wire [31:0] cur_shot;
  wire        ilo_allowed;
  wire        int_sync;
  wire        int_hot_bus_dead_line_check;
  wire        int_hot_line_dead_bus_check;
  wire        src_sync;
  wire        src_hot_bus_dead_line_check;
  wire        src_hot_line_dead_bus_check;
  wire        perm;
  wire        last_shot;
  wire        wr;
  wire        rd;
  integer     i;

  // clamp requested shots to one..four
  assign shots_set = ctrl_q[`CTRL_SHOTS_LO +: `CTRL_SHOTS_W];
  assign shots = (shots_set > `MAX_SHOTS) ? `MAX_SHOTS :
                 ((shots_set == 3'h0) ? 3'h1 : shots_set);
  assign idx = count_q[1:0];
  assign cur_shot = shot_q[idx];
  assign last_shot = ((count_q + 3'h1) == shots);

  // intermediate lockout honoured only on final shot
  assign ilo_allowed = ctrl_q[`CTRL_INTLO] & last_shot;

  // internal checks
  assign int_sync = (volt_diff_q <= lim_q[`LIM_W-1:0]) &&
                    (angle_q <= lim_q[2*`LIM_W-1:`LIM_W]);
  assign int_hot_bus_dead_line_check = bus_hot & line_dead;
  assign int_hot_line_dead_bus_check = line_hot & bus_dead;

  // source select
  assign src_sync = ctrl_q[`CTRL_EXT_SRC] ? ext_sync_ok : int_sync;
  assign src_hot_bus_dead_line_check = ctrl_q[`CTRL_EXT_SRC] ? ext_hot_bus_dead_line_check_ok : int_hot_bus_dead_line_check;
  assign src_hot_line_dead_bus_check = ctrl_q[`CTRL_EXT_SRC] ? ext_hot_line_dead_bus_check_ok : int_hot_line_dead_bus_check;

  // per-shot supervision, any selected check passing permits
  assign perm = ~(cur_shot[`SHOT_SYNC] | cur_shot[`SHOT_HOT_BUS_DEAD_LINE_CHECK] |
                  cur_shot[`SHOT_HOT_LINE_DEAD_BUS_CHECK]) |
                (cur_shot[`SHOT_SYNC] & src_sync) |
                (cur_shot[`SHOT_HOT_BUS_DEAD_LINE_CHECK] & src_hot_bus_dead_line_check) |
                (cur_shot[`SHOT_HOT_LINE_DEAD_BUS_CHECK] & src_hot_line_dead_bus_check);

  assign wr = psel & penable & pwrite & clk_en;
  assign rd = psel & ~penable & ~pwrite;

  // and/or of masked inputs
  function comb_out;
    input [7:0] in;
    input [7:0] mask;
    input       use_or;
    begin
      if (use_or) begin
        comb_out = |(in & mask);
      end else begin
        comb_out = (mask != 8'h00) && ((in & mask) == mask);
      end
    end
  endfunction

  // dead time of a shot, first one zero unless delayed
  function [15:0] dead_of;
    input [31:0] shot;
    input        first;
    input        delay_first;
    begin
      if (first && !delay_first) begin
        dead_of = 16'h0000;
      end else begin
        dead_of = shot[`SHOT_DT_W-1:0];
      end
    end
  endfunction

  // millisecond tick, frozen by hold
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      if (hold_in) begin
        tick_q <= 1'b0;
      end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
        tick_cnt_q <= 32'h0000_0000;
        tick_q <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        tick_q <= 1'b0;
      end
    end
  end

  // sequencer next state
  always @* begin
    state_d = state_q;
    count_d = count_q;
    timer_d = timer_q;
    close_d = 1'b0;
    fail_d = 1'b0;
    case (state_q)
      S_READY: begin
        if (ctrl_q[`CTRL_ENABLE] && breaker_open && reclose_initiate) begin
          state_d = S_DEAD;
          count_d = 3'h0;
          timer_d = dead_of(shot_q[0], 1'b1, ctrl_q[`CTRL_FIRST_DL]);
        end
      end
      S_DEAD: begin
        if (!breaker_open) begin
          state_d = S_RESET;
          timer_d = reset_t_q[15:0];
        end else if (skip_in) begin
          if (last_shot) begin
            state_d = S_LOCK;
            fail_d = 1'b1;
          end else begin
            count_d = count_q + 3'h1;
            timer_d = dead_of(shot_q[idx + 2'h1], 1'b0, 1'b1);
          end
        end else if (timer_q != 16'h0000) begin
          if (tick_q) begin
            timer_d = timer_q - 16'h0001;
          end
        end else if (perm && !hold_in) begin
          state_d = S_CLOSE;
          close_d = 1'b1;
          count_d = count_q + 3'h1;
        end else if (ilo_allowed) begin
          state_d = S_ILO;
        end else if (!perm) begin
          state_d = S_LOCK;
          fail_d = 1'b1;
        end
      end
      S_ILO: begin
        if (perm) begin
          state_d = S_CLOSE;
          close_d = 1'b1;
          count_d = count_q + 3'h1;
        end
      end
      S_CLOSE: begin
        if (breaker_open) begin
          close_d = 1'b1;
        end else begin
          state_d = S_RESET;
          timer_d = reset_t_q[15:0];
        end
      end
      S_RESET: begin
        if (breaker_open) begin
          if (count_q >= shots) begin
            state_d = S_LOCK;
          end else begin
            state_d = S_DEAD;
            timer_d = dead_of(shot_q[idx], 1'b0, 1'b1);
          end
        end else if (timer_q == 16'h0000) begin
          state_d = S_READY;
          count_d = 3'h0;
        end else if (tick_q) begin
          timer_d = timer_q - 16'h0001;
        end
      end
      S_LOCK: begin
        if (manual_close) begin
          close_d = breaker_open;
          if (!breaker_open) begin
            state_d = S_READY;
            count_d = 3'h0;
          end
        end
      end
      default: begin
        state_d = S_LOCK;
      end
    endcase
    if (drive_lockout) begin
      state_d = S_LOCK;
      close_d = 1'b0;
    end
  end

  // sequencer state and outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_READY;
      count_q <= 3'h0;
      timer_q <= 16'h0000;
      close_cmd <= 1'b0;
      alarm_check_fail <= 1'b0;
      alarm_intermediate_lockout <= 1'b0;
      alarm_reclose_fail <= 1'b0;
      alarm_lockout <= 1'b0;
      alarm_in_progress <= 1'b0;
      prog_out <= 2'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      count_q <= count_d;
      timer_q <= timer_d;
      close_cmd <= close_d;
      alarm_check_fail <= (state_d == S_ILO) ||
                          ((state_q == S_DEAD) && (timer_q == 16'h0000) &&
                           !perm);
      alarm_intermediate_lockout <= (state_d == S_ILO);
      if (fail_d) begin
        alarm_reclose_fail <= 1'b1;
      end else if (state_d == S_READY) begin
        alarm_reclose_fail <= 1'b0;
      end
      alarm_lockout <= (state_d == S_LOCK);
      alarm_in_progress <= (state_d == S_DEAD) || (state_d == S_CLOSE) ||
                           (state_d == S_RESET);
      for (i = 0; i < 2; i = i + 1) begin
        prog_out[i] <= comb_out(prog_in, logic_q[8*i +: 8],
                                logic_q[`LOGIC_OR_BIT + i]);
      end
    end
  end

  // apb register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RST;
      for (i = 0; i < 4; i = i + 1) begin
        shot_q[i] <= 32'h0000_0000;
      end
      reset_t_q <= `RESET_T_RST;
      lim_q <= 32'h0000_0000;
      logic_q <= 32'h0000_0000;
      volt_diff_q <= 16'h0000;
      angle_q <= 16'h0000;
    end else if (wr) begin
      case (paddr)
        `REG_CTRL:     ctrl_q <= pwdata;
        `REG_SHOT0:    shot_q[0] <= pwdata;
        `REG_SHOT1:    shot_q[1] <= pwdata;
        `REG_SHOT2:    shot_q[2] <= pwdata;
        `REG_SHOT3:    shot_q[3] <= pwdata;
        `REG_RESET_T:  reset_t_q <= pwdata;
        `REG_SYNC_LIM: lim_q <= pwdata;
        `REG_LOGIC:    logic_q <= pwdata;
        `REG_MEAS: begin
          volt_diff_q <= pwdata[`LIM_W-1:0];
          angle_q <= pwdata[2*`LIM_W-1:`LIM_W];
        end
        default: ;
      endcase
    end
  end

  // apb read data and ready
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel & ~penable) begin
        pslverr <= (paddr[1:0] != 2'h0) || (paddr > `REG_MEAS);
      end
      if (rd) begin
        case (paddr)
          `REG_CTRL:     prdata <= ctrl_q;
          `REG_SHOT0:    prdata <= shot_q[0];
          `REG_SHOT1:    prdata <= shot_q[1];
          `REG_SHOT2:    prdata <= shot_q[2];
          `REG_SHOT3:    prdata <= shot_q[3];
          `REG_RESET_T:  prdata <= reset_t_q;
          `REG_SYNC_LIM: prdata <= lim_q;
          `REG_LOGIC:    prdata <= logic_q;
          `REG_STATUS:   prdata <= {16'h0000, 4'h0, count_q, perm,
                                    1'b0, state_q, 2'h0, prog_out};
          `REG_MEAS:     prdata <= {angle_q, volt_diff_q};
          default:       prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // reclose_sequencer_sync_supervision

`default_nettype wire

// file: pkg/reclose_map.vh
`ifndef RECLOSE_MAP_VH
`define RECLOSE_MAP_VH

// register byte addresses
`define REG_CTRL      12'h000
`define REG_SHOT0     12'h004
`define REG_SHOT1     12'h008
`define REG_SHOT2     12'h00c
`define REG_SHOT3     12'h010
`define REG_RESET_T   12'h014
`define REG_SYNC_LIM  12'h018
`define REG_LOGIC     12'h01c
`define REG_STATUS    12'h020
`define REG_MEAS      12'h024

// control fields
`define CTRL_ENABLE   0
`define CTRL_EXT_SRC  1
`define CTRL_FIRST_DL 2
`define CTRL_INTLO    3
`define CTRL_SHOTS_LO 4
`define CTRL_SHOTS_W  3

// per-shot fields: dead time low 16, select bits above
`define SHOT_DT_W     16
`define SHOT_SYNC     16
`define SHOT_HOT_BUS_DEAD_LINE_CHECK     17
`define SHOT_HOT_LINE_DEAD_BUS_CHECK     18

// limits word: voltage diff low 16, angle high 16
`define LIM_W         16

// logic word: for output k, and/or select at bit 16+k, mask at 8*k
`define LOGIC_OR_BIT  16

// timebase: one tick per millisecond at 50 MHz
`define TICK_MS_NS    1000000
`define CLK_NS        20

`define MAX_SHOTS     3'h4

// reset values
`define CTRL_RST      32'h0000_0011
`define RESET_T_RST   32'h0000_03e8

`endif

// file: verif/reclose_sequencer_sync_supervision_properties.sv
`timescale 1ns/100ps
`default_nettype none
module reclose_checker (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // sequencer
  input wire logic        manual_close,
  input wire logic        drive_lockout,
  input wire logic        close_cmd,
  input wire logic        alarm_intermediate_lockout,
  input wire logic        alarm_lockout
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic setup;
  // setup phase of an apb transfer
  assign setup = psel && !penable && clk_en;
  a_pready_setup: assert property (setup |=> pready)
    else $error("no pready after setup");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_slverr_range: assert property (setup && paddr > 12'h024 |=> pslverr)
    else $error("no error on unmapped address");
  a_slverr_clean: assert property (setup && paddr <= 12'h024
    && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("error on mapped address");
  a_force_lockout: assert property (drive_lockout && clk_en |->
    ##[1:2] alarm_lockout && !close_cmd)
    else $error("lockout not forced");
  a_lock_no_close: assert property (alarm_lockout && !manual_close
    && !close_cmd |=> !close_cmd)
    else $error("close from lockout without request");
  a_intlo_no_close: assert property (alarm_intermediate_lockout
    |-> !close_cmd)
    else $error("close during intermediate lockout");
  a_close_cause: assert property ($rose(close_cmd)
    |-> !$past(drive_lockout))
    else $error("close after lockout drive");
endmodule // reclose_checker
`default_nettype wire

// file: verif/breaker_model.sv
`timescale 1ns/100ps
`default_nettype none
module breaker_model (
  // clock and reset
  input wire logic  pclk,
  input wire logic  presetn,
  // commands
  input wire logic  close_cmd,
  input wire logic  trip,
  input wire logic  slow,
  // contact state
  output logic      breaker_open
);
  logic [2:0] cnt_q;
  // trip opens, close command closes after a short or long stroke
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      breaker_open <= 1'b0;
      cnt_q        <= 3'h0;
    end else if (trip) begin
      breaker_open <= 1'b1;
      cnt_q        <= 3'h0;
    end else if (close_cmd && breaker_open) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == (slow ? 3'h5 : 3'h1))
        breaker_open <= 1'b0;
    end else
      cnt_q <= 3'h0;
  end
endmodule // breaker_model
`default_nettype wire

// file: verif/reclose_sequencer_sync_supervision_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "reclose_map.vh"
module reclose_sequencer_sync_supervision_tb;
  logic        pclk, presetn, psel, penable, pwrite, trip, slow, err, en;
  logic        reclose_initiate, manual_close, hold_in, skip_in;
  logic        drive_lockout, ext_sync_ok, ext_hot_bus_dead_line_check_ok, ext_hot_line_dead_bus_check_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd;
  logic [7:0]  prog_in;
  wire  [31:0] prdata;
  wire         pready, pslverr, breaker_open, close_cmd;
  wire  [1:0]  prog_out;
  wire  [5:0]  obs;
  int          num_errors, checked, i;
  logic [7:0]  pin [3] = '{8'h01, 8'h07, 8'h08};
  logic [1:0]  pexp [3] = '{2'h0, 2'h3, 2'h2};

  reclose_sequencer_sync_supervision #(.TICK_CYCLES(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .breaker_open(breaker_open), .reclose_initiate(reclose_initiate),
    .manual_close(manual_close), .hold_in(hold_in), .skip_in(skip_in),
    .drive_lockout(drive_lockout), .ext_sync_ok(ext_sync_ok),
    .ext_hot_bus_dead_line_check_ok(ext_hot_bus_dead_line_check_ok), .ext_hot_line_dead_bus_check_ok(ext_hot_line_dead_bus_check_ok),
    .line_hot(1'b0), .line_dead(1'b0), .bus_hot(1'b0), .bus_dead(1'b0),
    .prog_in(prog_in), .prog_out(prog_out), .close_cmd(close_cmd),
    .alarm_check_fail(obs[1]), .alarm_intermediate_lockout(obs[2]),
    .alarm_reclose_fail(obs[3]), .alarm_lockout(obs[4]),
    .alarm_in_progress(obs[5]));
  assign obs[0] = close_cmd;

  breaker_model i_brk (.pclk(pclk), .presetn(presetn),
    .close_cmd(close_cmd), .trip(trip), .slow(slow),
    .breaker_open(breaker_open));

  // clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task conclude;
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask

  task tmo;
    num_errors++;
    $display("MISMATCH %0t wait ran out", $time);
    conclude();
  endtask

  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) tmo();
  endtask

  task wait_sig(input int k, input logic v, input int lim);
    int n;
    for (n = 0; n < lim && obs[k] !== v; n++) @(posedge pclk);
    checked++;
    if (obs[k] !== v) tmo();
  endtask

  task stay(input int k, input int cyc);
    repeat (cyc) begin
      @(posedge pclk);
      chk(obs[k], 0);
    end
  endtask

  task trip_go;
    trip <= 1'b1;
    reclose_initiate <= 1'b1;
    @(posedge pclk);
    trip <= 1'b0;
    @(posedge pclk);
    reclose_initiate <= 1'b0;
  endtask

  task unlock;
    manual_close <= 1'b1;
    wait_sig(0, 1, 10);
    wait_sig(4, 0, 20);
    manual_close <= 1'b0;
  endtask

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, trip, slow, manual_close} = 0;
    {reclose_initiate, hold_in, skip_in, drive_lockout} = 0;
    {ext_sync_ok, ext_hot_bus_dead_line_check_ok, ext_hot_line_dead_bus_check_ok} = 0;
    {paddr, pwdata, prog_in} = 0;
    en = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, `REG_CTRL, 0);
    chk(rd, `CTRL_RST);
    apb(0, `REG_RESET_T, 0);
    chk(rd, `RESET_T_RST);
    apb(0, 12'h028, 0);
    chk(err, 1);
    apb(1, `REG_RESET_T, 3);
    apb(1, `REG_SHOT1, 2);
    apb(1, `REG_CTRL, 32'h21);
    apb(1, `REG_LOGIC, 32'h0002_0c03);
    for (i = 0; i < 3; i++) begin
      prog_in <= pin[i];
      repeat (3) @(posedge pclk);
      chk(prog_out, pexp[i]);
    end
    trip_go();
    wait_sig(0, 1, 6);
    wait_sig(5, 1, 4);
    apb(0, `REG_STATUS, 0);
    chk(rd[11:9], 1);
    wait_sig(5, 0, 60);
    apb(0, `REG_STATUS, 0);
    chk(rd[11:9], 0);
    slow <= 1'b1;
    trip_go();
    wait_sig(0, 1, 6);
    wait_sig(0, 0, 20);
    trip_go();
    stay(0, 5);
    wait_sig(0, 1, 12);
    wait_sig(0, 0, 20);
    trip_go();
    wait_sig(4, 1, 6);
    stay(0, 10);
    unlock();
    apb(1, `REG_SHOT0, 2);
    apb(1, `REG_CTRL, 32'h25);
    trip_go();
    hold_in <= 1'b1;
    stay(0, 30);
    hold_in <= 1'b0;
    wait_sig(0, 1, 12);
    wait_sig(5, 0, 60);
    trip_go();
    skip_in <= 1'b1;
    @(posedge pclk);
    skip_in <= 1'b0;
    wait_sig(0, 1, 20);
    wait_sig(0, 0, 20);
    trip_go();
    wait_sig(4, 1, 6);
    unlock();
    trip_go();
    drive_lockout <= 1'b1;
    @(posedge pclk);
    drive_lockout <= 1'b0;
    wait_sig(4, 1, 4);
    stay(0, 12);
    unlock();
    apb(1, `REG_CTRL, 32'h13);
    for (i = 0; i < 3; i++) begin
      apb(1, `REG_SHOT0, 32'h1 << (16 + i));
      {ext_hot_line_dead_bus_check_ok, ext_hot_bus_dead_line_check_ok, ext_sync_ok} <= 3'h1 << i;
      trip_go();
      wait_sig(0, 1, 8);
      wait_sig(5, 0, 60);
    end
    {ext_hot_line_dead_bus_check_ok, ext_hot_bus_dead_line_check_ok, ext_sync_ok} <= 3'h0;
    apb(1, `REG_SHOT0, 32'h0001_0000);
    trip_go();
    wait_sig(3, 1, 12);
    wait_sig(4, 1, 4);
    unlock();
    apb(1, `REG_CTRL, 32'h1b);
    trip_go();
    wait_sig(2, 1, 12);
    stay(0, 40);
    chk(obs[2], 1);
    ext_sync_ok <= 1'b1;
    wait_sig(0, 1, 8);
    wait_sig(2, 0, 4);
    wait_sig(5, 0, 60);
    ext_sync_ok <= 1'b0;
    apb(1, `REG_CTRL, 32'h2b);
    trip_go();
    stay(2, 20);
    conclude();
  end
endmodule // reclose_sequencer_sync_supervision_tb

bind reclose_sequencer_sync_supervision reclose_checker i_chk (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .manual_close(manual_close), .drive_lockout(drive_lockout),
  .close_cmd(close_cmd), .alarm_lockout(alarm_lockout),
  .alarm_intermediate_lockout(alarm_intermediate_lockout));
`default_nettype wire
